// File: core/audio_serial.sv
// serial audio port: apb registers, transmit fifo, word alignment and bit shifting
// assumes bit clock and word select arrive from outside, sampled on clk
//
// Behaviour
// - width code 010/011/100/101/110 selects 18/20/22/24/32 bit samples.
// - left alignment takes bits 31 down to 32 minus the width.
// - right alignment takes bits width-1 down to 0.
// - at 32 bits every register bit is used and alignment is ignored.
// - delay bit 0 starts data one bit clock after word select changes, 1 starts at once.
// - slave transmit with no delay is unsupported, yet delay 0 is advised there.
`timescale 1ns/1ps
module audio_serial (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bit_clock,
    input wire logic word_select_line,
    input wire logic serial_data_in,
    output logic serial_data_line,
    output logic serial_data_oe
);
    ////////////////////////////////////////////////////////////////////
    logic [8:0] ctrl_q;
    logic [31:0] sample_receive_reg_q;
    logic [31:0] rx_shift_q;
    logic [31:0] tx_shift_q;
    logic [5:0] bit_cnt_q;
    logic [2:0] bck_sync_q;
    logic [2:0] ws_sync_q;
    logic [1:0] din_sync_q;
    logic rx_full_q;
    logic underrun_q;
    logic pending_q;
    logic [2:0] sample_width_select;
    logic sample_alignment_select;
    logic data_delay_select;
    logic compressed_mode_enable;
    logic transfer_direction;
    logic enable;
    logic [5:0] width_bits;
    logic bck_rise;
    logic bck_fall;
    logic ws_edge;
    logic wr_en;
    logic rd_en;
    logic [31:0] tx_word;
    sample_fifo_if #(.width(audio_pkg::word_bits)) tx_if ();

    assign sample_width_select = ctrl_q[audio_pkg::width_lsb +: 3];
    assign sample_alignment_select = ctrl_q[audio_pkg::align_bit];
    assign data_delay_select = ctrl_q[audio_pkg::delay_bit];
    assign compressed_mode_enable = ctrl_q[audio_pkg::compress_bit];
    assign transfer_direction = ctrl_q[audio_pkg::dir_bit];
    assign enable = ctrl_q[audio_pkg::enable_bit];

    // width decode; other codes fall back to 32
    always_comb begin
        unique case (sample_width_select)
            audio_pkg::width_18: width_bits = 6'd18;
            audio_pkg::width_20: width_bits = 6'd20;
            audio_pkg::width_22: width_bits = 6'd22;
            audio_pkg::width_24: width_bits = 6'd24;
            default: width_bits = 6'd32;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // apb: single wait-free access phase, unmapped addresses error
    // strobes qualified by pready so a held access phase acts only once
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && pready;
    assign tx_if.in_valid = wr_en && (paddr == audio_pkg::tx_addr);
    assign tx_if.in_data = pwdata;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == audio_pkg::ctrl_addr || paddr == audio_pkg::tx_addr
                       || paddr == audio_pkg::rx_addr || paddr == audio_pkg::stat_addr);
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    audio_pkg::ctrl_addr: prdata <= {23'h0, ctrl_q};
                    audio_pkg::rx_addr: prdata <= sample_receive_reg_q;
                    audio_pkg::stat_addr: prdata <= {28'h0, underrun_q, rx_full_q,
                                                     tx_if.out_valid, tx_if.in_ready};
                    default: prdata <= '0;
                endcase
            end
        end
    end
    // the access phase completes the cycle pready is high
    logic apb_done;
    assign apb_done = pready && penable && psel;

    // control register; delay and compressed bits left as written
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= audio_pkg::ctrl_reset;
        end else if (apb_done && pwrite && paddr == audio_pkg::ctrl_addr) begin
            ctrl_q <= pwdata[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    sample_fifo #(.width(audio_pkg::word_bits), .depth(audio_pkg::fifo_depth)) u_tx_fifo (
        .clk(clk),
        .rstn(rstn),
        .port_io(tx_if)
    );

    // pin synchronisers, edges found only past the second stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bck_sync_q <= '1; // bit clock idles high, avoids a false edge after reset
            ws_sync_q <= '0;
            din_sync_q <= '0;
        end else begin
            bck_sync_q <= {bck_sync_q[1:0], bit_clock};
            ws_sync_q <= {ws_sync_q[1:0], word_select_line};
            din_sync_q <= {din_sync_q[0], serial_data_in};
        end
    end
    assign bck_rise = bck_sync_q[1] && !bck_sync_q[2];
    assign bck_fall = !bck_sync_q[1] && bck_sync_q[2];
    assign ws_edge = ws_sync_q[1] != ws_sync_q[2];

    // align a fifo word to msb first, zero padded
    always_comb begin
        if (width_bits == 6'd32) begin
            tx_word = tx_if.out_data;
        end else if (sample_alignment_select) begin
            tx_word = tx_if.out_data << (6'd32 - width_bits);
        end else begin
            tx_word = tx_if.out_data & ~(32'hffffffff >> width_bits);
        end
    end
    // pop exactly when the shifter loads, so a delayed frame sends its own word
    assign tx_if.out_ready = enable && transfer_direction && bck_fall
                             && ((ws_edge && data_delay_select) || pending_q);

    ////////////////////////////////////////////////////////////////////
    // word select edge arms a frame; delay bit picks which falling edge loads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending_q <= 1'b0;
            bit_cnt_q <= '0;
            tx_shift_q <= '0;
            underrun_q <= 1'b0;
        end else begin
            // clear first so a same-cycle underrun below still wins
            if (rd_en && paddr == audio_pkg::stat_addr) begin
                underrun_q <= 1'b0;
            end
            if (bck_fall) begin
            // delay bit used as written, also for slave transmit
            pending_q <= ws_edge && !data_delay_select;
            if ((ws_edge && data_delay_select) || pending_q) begin
                tx_shift_q <= (tx_if.out_valid && enable && transfer_direction) ? tx_word : '0;
                bit_cnt_q <= width_bits;
                underrun_q <= underrun_q || (enable && transfer_direction && !tx_if.out_valid);
            end else if (bit_cnt_q != '0) begin
                tx_shift_q <= {tx_shift_q[30:0], 1'b0};
                bit_cnt_q <= bit_cnt_q - 6'd1;
            end
            end
        end
    end
    // data pin drives msb, zero past the sample width
    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_data_line <= 1'b0;
            serial_data_oe <= 1'b0;
        end else begin
            serial_data_oe <= enable && transfer_direction;
            serial_data_line <= (bit_cnt_q != '0) ? tx_shift_q[31] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive: sample on rising edge, place by alignment at frame end
    logic [5:0] rx_cnt_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_shift_q <= '0;
            rx_cnt_q <= '0;
            sample_receive_reg_q <= '0;
            rx_full_q <= 1'b0;
        end else begin
            // clear first so a store in the same cycle still sets the flag
            if (rd_en && paddr == audio_pkg::rx_addr) begin
                rx_full_q <= 1'b0;
            end
            if (bck_rise && enable && !transfer_direction && bit_cnt_q != '0) begin
                rx_shift_q <= {rx_shift_q[30:0], din_sync_q[1]};
                rx_cnt_q <= rx_cnt_q + 6'd1;
            end else if (rx_cnt_q == width_bits) begin
                rx_cnt_q <= '0;
                rx_full_q <= 1'b1;
                if (width_bits == 6'd32 || sample_alignment_select) begin
                    sample_receive_reg_q <= rx_shift_q;
                end else begin
                    sample_receive_reg_q <= rx_shift_q << (6'd32 - width_bits);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_WIDTH_20: assert property (@(posedge clk) disable iff (!rstn)
        sample_width_select == audio_pkg::width_20 |-> width_bits == 6'd20)
        else $error("width decode wrong");
    AST_DELAY_NONE: assert property (@(posedge clk) disable iff (!rstn)
        bck_fall && ws_edge && data_delay_select |=> bit_cnt_q == $past(width_bits))
        else $error("no-delay frame did not load");
    AST_DELAY_ONE: assert property (@(posedge clk) disable iff (!rstn)
        bck_fall && ws_edge && !data_delay_select |=> pending_q)
        else $error("delayed frame not armed");
    AST_LEFT: assert property (@(posedge clk) disable iff (!rstn)
        width_bits != 6'd32 && !sample_alignment_select |-> (tx_word << width_bits) == 32'h0)
        else $error("left alignment leaks low bits");
    AST_FULL: assert property (@(posedge clk) disable iff (!rstn)
        width_bits == 6'd32 |-> tx_word == tx_if.out_data)
        else $error("32 bit word altered");
    AST_RIGHT: assert property (@(posedge clk) disable iff (!rstn)
        width_bits != 6'd32 && sample_alignment_select |-> (tx_word >> (6'd32 - width_bits))
        == (tx_if.out_data & ~(32'hffffffff << width_bits)))
        else $error("right alignment wrong");
    AST_PAD: assert property (@(posedge clk) disable iff (!rstn)
        bit_cnt_q == '0 |=> !serial_data_line)
        else $error("data beyond width not zero");
    AST_APB: assert property (@(posedge clk) disable iff (!rstn)
        psel && !penable |=> pready)
        else $error("apb answer late");
endmodule // audio_serial

// File: core/audio_pkg.sv
// constants for the serial audio word alignment block
// assumes an apb master on clk and an external codec on the pins
package audio_pkg;
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] tx_addr = 12'h004;
    localparam logic [11:0] rx_addr = 12'h008;
    localparam logic [11:0] stat_addr = 12'h00c;
    localparam int width_lsb = 0;
    localparam int align_bit = 3;
    localparam int delay_bit = 4;
    localparam int compress_bit = 5;
    localparam int wsdir_bit = 6;
    localparam int dir_bit = 7;
    localparam int enable_bit = 8;
    localparam logic [8:0] ctrl_reset = 9'h000;
    localparam logic [2:0] width_18 = 3'h2;
    localparam logic [2:0] width_20 = 3'h3;
    localparam logic [2:0] width_22 = 3'h4;
    localparam logic [2:0] width_24 = 3'h5;
    localparam logic [2:0] width_32 = 3'h6;
    localparam int fifo_depth = 32;
    localparam int word_bits = 32;
endpackage

// File: core/sample_fifo_if.sv
// handshake bundle between the fifo and its users
// assumes one clock domain
`timescale 1ns/1ps
interface sample_fifo_if #(parameter int width = 32);
    logic in_valid;
    logic in_ready;
    logic [width-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [width-1:0] out_data;
    modport fifo (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
    modport user (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
endinterface // sample_fifo_if

// File: core/sample_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes a synchronous active-low reset on clk
`timescale 1ns/1ps
module sample_fifo #(
    parameter int width = 32,
    parameter int depth = 32
) (
    input wire logic clk,
    input wire logic rstn,
    sample_fifo_if.fifo port_io
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem_q [depth];
    logic [aw-1:0] rd_q;
    logic [aw-1:0] wr_q;
    logic [aw:0] count_q;
    logic push;
    logic pop;

    // honest full and empty from the count
    assign port_io.in_ready = (count_q != (aw+1)'(depth));
    assign port_io.out_valid = (count_q != '0);
    assign port_io.out_data = mem_q[rd_q];
    assign push = port_io.in_valid && port_io.in_ready;
    assign pop = port_io.out_valid && port_io.out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= port_io.in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_q <= '0;
            wr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == aw'(depth-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == aw'(depth-1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + (aw+1)'(push) - (aw+1)'(pop);
        end
    end
endmodule // sample_fifo

// File: dv/audio_codec_model.sv
// behavioural codec on the far side of the serial audio port
// assumes the port is a slave: this model drives bit clock and word select
`timescale 1ns/1ps
module audio_codec_model (
    output logic bit_clock,
    output logic word_select_line,
    output logic serial_data_in,
    input wire logic serial_data_line,
    input wire logic serial_data_oe
);
    // bit clock idles high between calls, so it stands still outside frames
    initial begin
        bit_clock = 1'b1;
        word_select_line = 1'b0;
        serial_data_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one word-select phase of 32 bit clocks; ws flips on the first fall
    task automatic phase(output logic [31:0] word);
        #3.7;
        for (int i = 0; i < 32; i++) begin
            bit_clock = 1'b0;
            if (i == 0) begin
                word_select_line = ~word_select_line;
            end
            serial_data_in = ~serial_data_in; // changing pattern, never a stale level
            #62.5;
            bit_clock = 1'b1;
            // msb arrives first; an undriven line captures as unknown
            word[31 - i] = serial_data_oe ? serial_data_line : 1'bx;
            #62.5;
        end
    endtask
endmodule // audio_codec_model

// File: dv/audio_serial_tb.sv
// self-checking bench: apb master, codec model, width/alignment/delay table
// assumes the apb slave answers in its own time and the codec owns the link clock
`timescale 1ns/1ps
module audio_serial_tb;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cap, exp_w;
    logic bit_clock, word_select_line, serial_data_in, serial_data_line, serial_data_oe, err;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    // configuration table: width code, right align, no delay, compressed
    localparam logic [2:0] cfg_code [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h6, 3'h6};
    localparam logic [6:0] cfg_align = 7'h3c;
    localparam logic [6:0] cfg_delay = 7'h2a;
    localparam logic [6:0] cfg_comp = 7'h08;

    audio_serial DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_clock(bit_clock), .word_select_line(word_select_line), .serial_data_in(serial_data_in),
        .serial_data_line(serial_data_line), .serial_data_oe(serial_data_oe));
    audio_codec_model codec (.bit_clock(bit_clock), .word_select_line(word_select_line),
        .serial_data_in(serial_data_in), .serial_data_line(serial_data_line),
        .serial_data_oe(serial_data_oe));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // one apb transfer; entered just after a rising edge, released one edge before the next
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // transmit enabled, word select taken as input (slave transmitter)
    function automatic logic [31:0] ctrl_word(input logic [2:0] c, input logic al, input logic dl, input logic cp);
        return 32'h0000_0180 | 32'(c) | (32'(al) << audio_pkg::align_bit) | (32'(dl) << audio_pkg::delay_bit)
            | (32'(cp) << audio_pkg::compress_bit);
    endfunction
    // serial image of a register word: kept bits pushed to the msb end, zeros behind
    function automatic logic [31:0] expect_word(input logic [2:0] c, input logic al, input logic [31:0] r);
        int w;
        w = (c == 3'h2) ? 18 : (c == 3'h3) ? 20 : (c == 3'h4) ? 22 : (c == 3'h5) ? 24 : 32;
        if (w == 32) return r;
        if (al) return r << (32 - w);
        return r & (32'hffff_ffff << (32 - w));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, audio_pkg::ctrl_addr, 32'h0);
        check(rd, 32'(audio_pkg::ctrl_reset));
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({28'h0, rd[3:0]}, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0); // unmapped place
        check({31'h0, err}, 32'h0000_0001);
        // every width code, both alignments, both delays; delay 0 here is slave transmit
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, audio_pkg::ctrl_addr, ctrl_word(cfg_code[i], cfg_align[i], cfg_delay[i], cfg_comp[i]));
            apb(1'b0, audio_pkg::ctrl_addr, 32'h0);
            check(rd, ctrl_word(cfg_code[i], cfg_align[i], cfg_delay[i], cfg_comp[i]));
            exp_w = expect_word(cfg_code[i], cfg_align[i], 32'ha5c3_96e1 ^ (32'h1111_1111 * i));
            apb(1'b1, audio_pkg::tx_addr, 32'ha5c3_96e1 ^ (32'h1111_1111 * i));
            codec.phase(cap);
            if (cfg_delay[i]) check(cap, exp_w);
            else check(cap, {1'b0, exp_w[31:1]});
            codec.phase(cap);
            @(posedge clk);
        end
        // fill the transmit fifo past its depth while the port is idle
        apb(1'b1, audio_pkg::ctrl_addr, 32'h0);
        for (int i = 0; i <= audio_pkg::fifo_depth; i++) apb(1'b1, audio_pkg::tx_addr, 32'h0100_0000 * i + i);
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({30'h0, rd[1:0]}, 32'h0000_0002);
        // drain: the word offered beyond the depth must never appear
        apb(1'b1, audio_pkg::ctrl_addr, ctrl_word(3'h6, 1'b0, 1'b1, 1'b0));
        for (int i = 0; i < audio_pkg::fifo_depth; i++) begin
            codec.phase(cap);
            check(cap, 32'h0100_0000 * i + i);
        end
        codec.phase(cap);
        @(posedge clk);
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({29'h0, rd[3], rd[1:0]}, 32'h0000_0005);
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({31'h0, rd[3]}, 32'h0000_0000);
        // receive one 32 bit frame: the codec's toggling data gives 1010... msb first
        apb(1'b1, audio_pkg::ctrl_addr, 32'h0000_0116);
        codec.phase(cap);
        @(posedge clk);
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({31'h0, rd[2]}, 32'h0000_0001);
        apb(1'b0, audio_pkg::rx_addr, 32'h0);
        check(rd, 32'haaaa_aaaa);
        apb(1'b0, audio_pkg::stat_addr, 32'h0);
        check({31'h0, rd[2]}, 32'h0000_0000);
        stop_test();
    end
endmodule // audio_serial_tb
